// ===== include/sast_pkg.sv
// sast_pkg: shared constants, types and register map of the annunciator block
// assumes: 32-bit apb, byte addresses, one word per register
`default_nettype none
package sast_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_LATCH  = 8'h00; // annunciator latch word
    localparam logic [7:0] ADDR_STATUS = 8'h04; // live status, read only
    localparam logic [7:0] ADDR_EVENT  = 8'h08; // sticky events, read clears
    localparam logic [7:0] ADDR_MASK   = 8'h0C; // event mask
    localparam logic [7:0] ADDR_TEST   = 8'h10; // self-test control and result
    localparam logic [7:0] ADDR_CAL    = 8'h14; // calibration control
    localparam logic [7:0] ADDR_LEVEL  = 8'h18; // leveling mode
    localparam logic [7:0] ADDR_DIAG   = 8'h1C; // diagnostic leds readback

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int LAT_OVEN    = 0;
    localparam int LAT_UNLOCK  = 1;
    localparam int LAT_FAULT   = 2;
    localparam int LAT_UNLEV   = 3;
    localparam int LAT_WIDTH   = 8;
    localparam int NUM_LOOPS   = 6;
    localparam int NUM_FAULTS  = 5;
    localparam int NUM_DIAG    = 16;
    localparam int FLT_CAL     = 0;
    localparam int FLT_KICK    = 1;
    localparam int FLT_ADC     = 2;
    localparam int FLT_PEAK    = 3;
    localparam int FLT_TRACK   = 4;
    localparam int EV_WIDTH    = 4;
    localparam int EV_OVEN     = 0;
    localparam int EV_UNLOCK   = 1;
    localparam int EV_FAULT    = 2;
    localparam int EV_TESTDONE = 3;

    // ------------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------------
    localparam logic [7:0]  LATCH_RESET = 8'h00;
    localparam logic [3:0]  MASK_RESET  = 4'h0;
    localparam logic [1:0]  LEVEL_INT   = 2'h0;
    localparam logic [1:0]  LEVEL_EXT_DETECTOR = 2'h1;
    localparam logic [1:0]  LEVEL_METER = 2'h2;
    localparam int          CLK_MHZ     = 125;
    localparam int          KICK_MAX_US = 100;  // longest legal kick pulse
    localparam int          KICK_CYC    = KICK_MAX_US * CLK_MHZ;
    localparam int          BLINK_CYC   = 62500000; // half period of name flash
    localparam logic [15:0] DIAG_PATTERN = 16'hA55A; // bus walk test word

    // self-test states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_START = 3'b001,
        ST_MEM   = 3'b010,
        ST_BUS   = 3'b011,
        ST_CHK   = 3'b100,
        ST_DONE  = 3'b101
    } sast_state_t;

    // status inputs grouped together
    typedef struct packed {
        logic                  oven_cold_flag;
        logic [NUM_LOOPS-1:0]  loop_unlock_indicator;
        logic                  unleveled;
        logic                  kick_active;
    } sast_status_t;

    // self-test results reported by the processor side
    typedef struct packed {
        logic mem_ok;   // rom, ram and cpu verified
        logic bus_ok;   // address bus and all data bits verified
        logic adc_ok;
    } sast_test_t;

endpackage
`default_nettype wire

// ===== src/sast_kick_timer.sv
// sast_kick_timer: measures one kick pulse and flags an overtime
// assumes: kick input already synchronised to pclk
`timescale 1ns/10ps
`default_nettype none
module sast_kick_timer #(
    parameter int KICK_CYC = sast_pkg::KICK_CYC
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic kick,
    output logic      overtime
);
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic        over_reg;
    logic        over_next;

    // count while the pulse stays high, saturate at the limit, restart when low
    always_comb begin
        cnt_next  = !kick ? 32'h0000_0000
                  : (cnt_reg >= 32'(KICK_CYC)) ? cnt_reg : cnt_reg + 32'h0000_0001;
        over_next = kick && (cnt_reg >= 32'(KICK_CYC)); // R13
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg  <= 32'h0000_0000;
            over_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            over_reg <= over_next;
        end
    end

    assign overtime = over_reg;
endmodule
`default_nettype wire

// ===== src/sast_top.sv
// sast_top: front-panel annunciators, check leds and self-test sequencer
// Operation
// R1: self-test starts at power-on and preset
// R2: both check leds lit at test start
// R3: check one off after memory and cpu pass
// R4: check two off after bus and data pass
// R5: both off implies all diagnostic leds off
// R6: oven light follows the oven-cold flag
// R7: processor puts bits, then writes latch address
// R8: unlock light when any loop unlocked
// R9: unlock detail flashes each unlocked loop name
// R10: fault light summarises five flashing sources
// R11: checksum checked only at power-on or preset
// R12: constant update recomputes checksum, clearing fault; here the fault clears only at the next ST_CHK
// R13: overlong kick pulse raises kick fault
// R14: adc checked at power-on and preset
// R15: peak and track faults from their operations
// R16: unleveled light follows leveled state
// R17: exactly one leveling-mode light lit
// R18: latch holds until next write
// assumes: apb master on pclk, status pins asynchronous to pclk
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module sast_top #(
    parameter int KICK_CYC  = sast_pkg::KICK_CYC,
    parameter int BLINK_CYC = sast_pkg::BLINK_CYC
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire sast_pkg::sast_status_t status_in,
    input  wire logic                   cal_sum_ok,
    input  wire logic                   instrument_preset,
    output logic [7:0]                  annunciator,
    output logic [1:0]                  check_led,
    output logic [15:0]                 diag_led,
    output logic [2:0]                  level_led,
    output logic [5:0]                  unlock_flash,
    output logic [4:0]                  fault_flash,
    output logic                        irq
);
    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    localparam int SW = $bits(sast_pkg::sast_status_t) + 2;
    logic [SW-1:0] sync1_reg;
    logic [SW-1:0] sync2_reg;

    // two flip-flops per asynchronous pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {status_in, cal_sum_ok, instrument_preset};
            sync2_reg <= sync1_reg;
        end
    end

    sast_pkg::sast_status_t st;
    logic                   cal_ok_s;
    logic                   preset_s;
    assign st       = sast_pkg::sast_status_t'(sync2_reg[SW-1:2]);
    assign cal_ok_s = sync2_reg[1];
    assign preset_s = sync2_reg[0];

    // ------------------------------------------------------------------
    // kick overtime detector
    // ------------------------------------------------------------------
    logic kick_over;
    sast_kick_timer #(.KICK_CYC(KICK_CYC)) sast_kick_timer_inst (
        .pclk     (pclk),
        .presetn  (presetn),
        .kick     (st.kick_active),
        .overtime (kick_over)
    );

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    logic wr_en;
    logic rd_en;
    logic known;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign known = (paddr[1:0] == 2'h0) && (paddr <= sast_pkg::ADDR_DIAG);

    // address match shared by the write decodes and the event read clear
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // ------------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------------
    sast_pkg::sast_state_t state_reg, state_next;
    logic [7:0]  latch_reg, latch_next;
    logic [1:0]  check_reg, check_next;
    logic [15:0] diag_reg, diag_next;
    logic [3:0]  event_reg, event_next;
    logic [3:0]  mask_reg, mask_next;
    logic [4:0]  fault_reg, fault_next;
    logic [1:0]  level_reg, level_next;
    logic [2:0]  res_reg, res_next;      // mem_ok, bus_ok, adc_ok
    logic        cal_force_reg, cal_force_next;
    logic        preset_d_reg;
    logic [31:0] blink_cnt_reg, blink_cnt_next;
    logic        blink_reg, blink_next;
    logic [31:0] rdata_next;
    logic [31:0] prdata_reg;
    logic        slverr_next;
    logic        slverr_reg;
    logic        irq_next;
    logic        irq_reg;
    logic [7:0]  ann_reg, ann_next;
    logic [2:0]  lvl_led_reg, lvl_led_next;
    logic [5:0]  uflash_reg, uflash_next;
    logic [4:0]  fflash_reg, fflash_next;
    logic [3:0]  ev_set;
    logic        any_unlock;
    logic        any_fault;

    assign any_unlock = |st.loop_unlock_indicator; // R8
    assign any_fault  = |fault_reg;                // R10

    // ------------------------------------------------------------------
    // self-test sequencer and register next values
    // ------------------------------------------------------------------
    always_comb begin
        state_next     = state_reg;
        latch_next     = latch_reg;
        check_next     = check_reg;
        diag_next      = diag_reg;
        mask_next      = mask_reg;
        level_next     = level_reg;
        res_next       = res_reg;
        cal_force_next = cal_force_reg;
        fault_next     = fault_reg;

        // preset edge restarts the test from any state
        if (preset_s && !preset_d_reg) begin
            state_next = sast_pkg::ST_START; // R1
        end else begin
            case (state_reg)
                sast_pkg::ST_IDLE: begin
                    state_next = sast_pkg::ST_IDLE;
                end
                sast_pkg::ST_START: begin
                    check_next = 2'b11;        // R2
                    diag_next  = 16'hFFFF;
                    res_next   = 3'b000;
                    state_next = sast_pkg::ST_MEM;
                end
                sast_pkg::ST_MEM: begin
                    if (res_reg[2]) begin
                        check_next[0] = 1'b0;  // R3
                        diag_next[7:0] = 8'h00;
                        state_next    = sast_pkg::ST_BUS;
                    end
                end
                sast_pkg::ST_BUS: begin
                    if (res_reg[1]) begin
                        check_next[1]  = 1'b0; // R4
                        diag_next[15:8] = 8'h00; // R5
                        state_next     = sast_pkg::ST_CHK;
                    end
                end
                sast_pkg::ST_CHK: begin
                    // checksum and adc judged here only
                    fault_next[sast_pkg::FLT_CAL] = !(cal_ok_s || cal_force_reg); // R11 R12
                    fault_next[sast_pkg::FLT_ADC] = !res_reg[0]; // R14
                    cal_force_next = 1'b0;
                    state_next = sast_pkg::ST_DONE;
                end
                sast_pkg::ST_DONE: begin
                    state_next = sast_pkg::ST_DONE;
                end
                default: begin
                    state_next = sast_pkg::ST_START;
                end
            endcase
        end

        // kick fault stays set until reset
        if (kick_over) begin
            fault_next[sast_pkg::FLT_KICK] = 1'b1; // R13
        end

        // software writes
        if (wr_en) begin
            if (hit(paddr, sast_pkg::ADDR_LATCH)) begin
                latch_next = pwdata[7:0]; // R7 R18
            end
            if (hit(paddr, sast_pkg::ADDR_MASK)) begin
                mask_next = pwdata[3:0];
            end
            if (hit(paddr, sast_pkg::ADDR_TEST)) begin
                res_next = res_reg | pwdata[2:0];
            end
            if (hit(paddr, sast_pkg::ADDR_CAL)) begin
                // bit0 constant updated, bit1 peak failed, bit2 track failed
                if (pwdata[0]) begin
                    cal_force_next = 1'b1; // R12
                end
                if (pwdata[1]) begin
                    fault_next[sast_pkg::FLT_PEAK] = 1'b1; // R15
                end
                if (pwdata[2]) begin
                    fault_next[sast_pkg::FLT_TRACK] = 1'b1; // R15
                end
                if (pwdata[3]) begin
                    fault_next[sast_pkg::FLT_PEAK]  = 1'b0;
                    fault_next[sast_pkg::FLT_TRACK] = 1'b0;
                end
            end
            if (hit(paddr, sast_pkg::ADDR_LEVEL) && (pwdata[1:0] != 2'h3)) begin
                level_next = pwdata[1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // events, read data and output images
    // ------------------------------------------------------------------
    always_comb begin
        ev_set[sast_pkg::EV_OVEN]   = st.oven_cold_flag;
        ev_set[sast_pkg::EV_UNLOCK] = any_unlock;
        ev_set[sast_pkg::EV_FAULT]  = any_fault;
        ev_set[sast_pkg::EV_TESTDONE] = (state_reg == sast_pkg::ST_CHK);
        // read clears, but a new event in the same cycle wins
        event_next = ((rd_en && hit(paddr, sast_pkg::ADDR_EVENT)) ? 4'h0 : event_reg) | ev_set;
        irq_next   = |(event_next & mask_next);

        rdata_next = 32'h0000_0000;
        case (paddr)
            sast_pkg::ADDR_LATCH:  rdata_next[7:0]  = latch_reg;
            sast_pkg::ADDR_STATUS: rdata_next[15:0] = {fault_reg, st.loop_unlock_indicator,
                                                       st.unleveled, st.oven_cold_flag,
                                                       st.kick_active, 2'b00};
            sast_pkg::ADDR_EVENT:  rdata_next[3:0]  = event_reg;
            sast_pkg::ADDR_MASK:   rdata_next[3:0]  = mask_reg;
            sast_pkg::ADDR_TEST:   rdata_next[7:0]  = {state_reg, check_reg, res_reg};
            sast_pkg::ADDR_CAL:    rdata_next[0]    = cal_force_reg;
            sast_pkg::ADDR_LEVEL:  rdata_next[1:0]  = level_reg;
            sast_pkg::ADDR_DIAG:   rdata_next[15:0] = diag_reg;
            default:               rdata_next       = 32'h0000_0000;
        endcase
        slverr_next = psel && !penable ? !known : slverr_reg;

        // latch drives processor-owned bits, live status forces the rest
        ann_next = latch_reg;
        ann_next[sast_pkg::LAT_OVEN]   = st.oven_cold_flag; // R6
        ann_next[sast_pkg::LAT_UNLOCK] = any_unlock;        // R8
        ann_next[sast_pkg::LAT_FAULT]  = any_fault;         // R10
        ann_next[sast_pkg::LAT_UNLEV]  = st.unleveled;      // R16

        // one-hot leveling lights
        case (level_reg)
            sast_pkg::LEVEL_EXT_DETECTOR: lvl_led_next = 3'b010; // R17
            sast_pkg::LEVEL_METER: lvl_led_next = 3'b100; // R17
            default:               lvl_led_next = 3'b001; // R17
        endcase

        // flashing names for the detail views
        blink_cnt_next = (blink_cnt_reg >= 32'(BLINK_CYC - 1)) ? 32'h0000_0000
                                                              : blink_cnt_reg + 32'h0000_0001;
        blink_next     = (blink_cnt_reg >= 32'(BLINK_CYC - 1)) ? !blink_reg : blink_reg;
        uflash_next    = blink_reg ? st.loop_unlock_indicator : 6'h00; // R9
        fflash_next    = blink_reg ? fault_reg : 5'h00;               // R10
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg     <= sast_pkg::ST_START; // R1
            latch_reg     <= sast_pkg::LATCH_RESET;
            check_reg     <= 2'b11;
            diag_reg      <= 16'hFFFF;
            event_reg     <= 4'h0;
            mask_reg      <= sast_pkg::MASK_RESET;
            fault_reg     <= 5'h00;
            level_reg     <= sast_pkg::LEVEL_INT;
            res_reg       <= 3'b000;
            cal_force_reg <= 1'b0;
            preset_d_reg  <= 1'b0;
            blink_cnt_reg <= 32'h0000_0000;
            blink_reg     <= 1'b0;
            prdata_reg    <= 32'h0000_0000;
            slverr_reg    <= 1'b0;
            irq_reg       <= 1'b0;
            ann_reg       <= 8'h00;
            lvl_led_reg   <= 3'b001;
            uflash_reg    <= 6'h00;
            fflash_reg    <= 5'h00;
        end else begin
            state_reg     <= state_next;
            latch_reg     <= latch_next;
            check_reg     <= check_next;
            diag_reg      <= diag_next;
            event_reg     <= event_next;
            mask_reg      <= mask_next;
            fault_reg     <= fault_next;
            level_reg     <= level_next;
            res_reg       <= res_next;
            cal_force_reg <= cal_force_next;
            preset_d_reg  <= preset_s;
            blink_cnt_reg <= blink_cnt_next;
            blink_reg     <= blink_next;
            prdata_reg    <= (psel && !penable) ? rdata_next : prdata_reg;
            slverr_reg    <= slverr_next;
            irq_reg       <= irq_next;
            ann_reg       <= ann_next;
            lvl_led_reg   <= lvl_led_next;
            uflash_reg    <= uflash_next;
            fflash_reg    <= fflash_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign prdata       = prdata_reg;
    assign pready       = 1'b1;
    assign pslverr      = slverr_reg;
    assign annunciator  = ann_reg;
    assign check_led    = check_reg;
    assign diag_led     = diag_reg;
    assign level_led    = lvl_led_reg;
    assign unlock_flash = uflash_reg;
    assign fault_flash  = fflash_reg;
    assign irq          = irq_reg;
endmodule
`default_nettype wire

// ===== test/sast_top_checker.sv
// sast_top_checker: port-level assertions for the annunciator block
// assumes: bound into sast_top, one pclk domain, async low reset
`timescale 1ns/10ps
`default_nettype none
module sast_top_checker (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [7:0]             paddr,
    input wire logic [31:0]            pwdata,
    input wire sast_pkg::sast_status_t status_in,
    input wire logic                   instrument_preset,
    input wire logic [7:0]             annunciator,
    input wire logic [1:0]             check_led,
    input wire logic [15:0]            diag_led,
    input wire logic [2:0]             level_led
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr;
    // a completed write to the latch word
    assign wr = psel && penable && pwrite && paddr == sast_pkg::ADDR_LATCH;
    // live lights settle within the sync chain and output register
    oven_light_a: assert property ($stable(status_in.oven_cold_flag) [*6]
        |-> annunciator[sast_pkg::LAT_OVEN] == status_in.oven_cold_flag) else $error("oven light");
    unlock_light_a: assert property ($stable(status_in.loop_unlock_indicator) [*6]
        |-> annunciator[sast_pkg::LAT_UNLOCK] == (|status_in.loop_unlock_indicator))
        else $error("unlock light");
    unlev_light_a: assert property ($stable(status_in.unleveled) [*6]
        |-> annunciator[sast_pkg::LAT_UNLEV] == status_in.unleveled) else $error("unlev light");
    // self-test indicators and leveling lights
    diag_cross_a: assert property (check_led == 2'h0 |-> diag_led == 16'h0000)
        else $error("diag leds lit");
    level_one_a: assert property ($onehot(level_led))
        else $error("level leds not one-hot");
    preset_restart_a: assert property ($rose(instrument_preset) |-> ##[1:8] check_led == 2'h3)
        else $error("check leds not relit");
    // latch bits load on a write and hold otherwise
    latch_load_a: assert property (wr ##1 !wr [*2]
        |-> annunciator[7:4] == $past(pwdata[7:4], 2)) else $error("latch not loaded");
    latch_hold_a: assert property (!wr [*3] |=> $stable(annunciator[7:4]))
        else $error("latch changed");
    cover property (wr);
    cover property (check_led == 2'h0);
    cover property ($rose(instrument_preset));
endmodule
bind sast_top sast_top_checker sast_top_checker_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .status_in(status_in),
    .instrument_preset(instrument_preset), .annunciator(annunciator),
    .check_led(check_led), .diag_led(diag_led), .level_led(level_led));
`default_nettype wire

// ===== test/sast_status_model.sv
// sast_status_model: far-side status sources (oven, loops, leveling, kick)
// assumes: levels change just after a rising pclk edge
`timescale 1ns/10ps
`default_nettype none
module sast_status_model (
    input  wire logic                  pclk,
    output var sast_pkg::sast_status_t status
);
    // steady levels, held until the next call
    task automatic drive(input logic o, input logic [5:0] u, input logic lv);
        @(posedge pclk);
        status.oven_cold_flag        <= o;
        status.loop_unlock_indicator <= u;
        status.unleveled             <= lv;
    endtask
    // one kick pulse of n cycles, then released
    task automatic kick(input int n);
        @(posedge pclk);
        status.kick_active <= 1'b1;
        repeat (n) @(posedge pclk);
        status.kick_active <= 1'b0;
    endtask
    initial status = '0;
endmodule
`default_nettype wire

// ===== test/status_annunciator_selftest_test.sv
// status_annunciator_selftest_test: apb-driven bench for sast_top
// assumes: sast_pkg compiled first, checker bound, status model alongside
`timescale 1ns/10ps
`default_nettype none
module status_annunciator_selftest_test;
    localparam int KC = 20;
    logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic                   cal_ok, preset, irq, serr;
    logic [7:0]             paddr, ann;
    logic [31:0]            pwdata, prdata, r, seen;
    logic [1:0]             chk_led;
    logic [15:0]            diag;
    logic [2:0]             lvl;
    logic [5:0]             ufl;
    logic [4:0]             ffl;
    sast_pkg::sast_status_t st;
    int                     err_total, num_checks;
    // clock
    always #4 pclk = ~pclk;
    sast_top #(.KICK_CYC(KC), .BLINK_CYC(4)) sast_top_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .status_in(st),
        .cal_sum_ok(cal_ok), .instrument_preset(preset), .annunciator(ann),
        .check_led(chk_led), .diag_led(diag), .level_led(lvl), .unlock_flash(ufl),
        .fault_flash(ffl), .irq(irq));
    sast_status_model sast_status_model_inst (.pclk(pclk), .status(st));
    // one apb transfer; read data kept in r
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
        if (n >= 20) begin
            chk("pready", 32'h1, 32'(pready));
            end_sim();
        end
        r       = prdata;
        serr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // compare one value
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        {pclk, presetn, psel, penable, pwrite, cal_ok, preset} = 7'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        err_total = 0;
        num_checks = 0;
        cyc(5);
        presetn <= 1'b1;
        cyc(3);
        chk("check", 32'h3, 32'(chk_led));
        apb(1'b1, sast_pkg::ADDR_TEST, 32'h4);
        cyc(4);
        chk("check", 32'h2, 32'(chk_led));
        apb(1'b1, sast_pkg::ADDR_TEST, 32'h2);
        cyc(4);
        chk("check", 32'h0, 32'(chk_led));
        chk("diag", 32'h0, 32'(diag));
        apb(1'b0, sast_pkg::ADDR_STATUS, 32'h0);
        chk("faults", 32'h5, 32'(r[15:11]));
        chk("fault light", 32'h1, 32'(ann[2]));
        seen = 32'h0;
        repeat (12) @(posedge pclk) seen = seen | 32'(ffl);
        chk("fault flash", 32'h5, seen);
        $display("selftest done");
        apb(1'b1, sast_pkg::ADDR_MASK, 32'h8);
        cyc(2);
        chk("irq", 32'h1, 32'(irq));
        apb(1'b0, sast_pkg::ADDR_EVENT, 32'h0);
        chk("event", 32'hC, r);
        cyc(2);
        chk("irq", 32'h0, 32'(irq));
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped", 32'h1, 32'(serr));
        $display("irq done");
        sast_status_model_inst.drive(1'b1, 6'h24, 1'b1);
        cyc(8);
        chk("lights", 32'hF, 32'(ann[3:0]));
        seen = 32'h0;
        repeat (12) @(posedge pclk) seen = seen | 32'(ufl);
        chk("unlock flash", 32'h24, seen);
        sast_status_model_inst.drive(1'b0, 6'h00, 1'b0);
        cyc(8);
        chk("lights", 32'h4, 32'(ann[3:0]));
        apb(1'b1, sast_pkg::ADDR_LATCH, 32'hA0);
        cyc(2);
        chk("latch", 32'hA, 32'(ann[7:4]));
        apb(1'b1, sast_pkg::ADDR_MASK, 32'h0);
        apb(1'b0, sast_pkg::ADDR_LATCH, 32'h0);
        chk("latch", 32'hA0, r);
        chk("latch", 32'hA, 32'(ann[7:4]));
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, sast_pkg::ADDR_LEVEL, 32'(i));
            cyc(2);
            chk("level", 32'h1 << (i > 2 ? 2 : i), 32'(lvl));
        end
        $display("lights done");
        for (int k = 0; k < 2; k++) begin
            sast_status_model_inst.kick(k == 1 ? KC + 5 : KC - 5);
            cyc(6);
            apb(1'b0, sast_pkg::ADDR_STATUS, 32'h0);
            chk("kick", 32'(k), 32'(r[12]));
        end
        for (int k = 1; k < 4; k++) begin
            apb(1'b1, sast_pkg::ADDR_CAL, 32'h1 << k);
            apb(1'b0, sast_pkg::ADDR_STATUS, 32'h0);
            chk("peak track", k == 3 ? 32'h0 : (32'h1 << k) - 32'h1, 32'(r[15:14]));
        end
        $display("fault sources done");
        cal_ok <= 1'b1;
        cyc(8);
        apb(1'b0, sast_pkg::ADDR_STATUS, 32'h0);
        chk("cal", 32'h1, 32'(r[11]));
        cal_ok <= 1'b0;
        apb(1'b1, sast_pkg::ADDR_CAL, 32'h1);
        preset <= 1'b1;
        seen = 32'h0;
        repeat (8) @(posedge pclk) seen = seen | 32'(chk_led == 2'h3);
        chk("check", 32'h1, seen);
        preset <= 1'b0;
        apb(1'b1, sast_pkg::ADDR_TEST, 32'h7);
        cyc(6);
        chk("check", 32'h0, 32'(chk_led));
        apb(1'b0, sast_pkg::ADDR_STATUS, 32'h0);
        chk("cal adc", 32'h0, 32'({r[13], r[11]}));
        $display("preset done");
        end_sim();
    end
endmodule
`default_nettype wire
